/* src/sbs_pkg.sv */
// Constants, field layouts and cycle encodings of the synchronous burst SRAM control block.
// Contract
// [RL1] Global write low, or byte write low with any lane low, means write.
// [RL2] Byte write writes only the lanes whose enable is low, others keep data.
// [RL3] Read cycles drive every byte lane regardless of lane enables.
// [RL4] Write cycles keep every data lane undriven regardless of lane enables.
// [RL5] Lanes two and three exist only in the 36-bit configuration.
// [RL6] Output enable high disables drivers at once; low only passes active drivers.
// [RL7] Chip select high with controller strobe low deselects, using no address.
// [RL8] Chip select low starts a read burst on cpu strobe, or ctrl strobe without write.
// [RL9] Chip select low, cpu strobe high, ctrl strobe low, write: start a write burst.
// [RL10] Both strobes high with step low continue the burst at the next address.
// [RL11] Both strobes high with step high repeat the access at the current address.
// [RL12] A read with output enable high still advances the counter like a read.
// [RL13] The controller holds output enable high long enough before driving write data.
// [RL14] Single accesses: tie cpu strobe high and controller strobe low.
// [RL15] Simple bursts: tie cpu strobe high, step low, pulse controller strobe per start.
// [RL16] The 2-bit counter starts at the low address bits and wraps after four.
// [RL17] Linear order counts modulo four; interleaved order XORs start with count.
// [RL18] Flow-through bypasses the output register; pipeline uses a rising-edge register.
// [RL19] Pipeline data comes one clock later; turn-off follows single or dual deselect.
package sbs_pkg;

  // The 36-bit configuration: four lanes of nine bits.
  localparam int LANE_CNT = 4;
  localparam int LANE_W = 9;
  localparam int DATA_W = LANE_CNT * LANE_W;
  localparam int ADDR_W = 4;
  localparam int DEPTH = 16;
  localparam int AXI_AW = 4;

  localparam logic [AXI_AW-1:0] CFG_OFFSET = 4'h0;
  localparam logic [AXI_AW-1:0] STATUS_OFFSET = 4'h4;

  localparam int CFG_FLOWTHRU_BIT = 0;
  localparam int CFG_LINEAR_BIT = 1;
  localparam int CFG_DESEL_BIT = 2;
  localparam logic CFG_FLOWTHRU_RST = 1'b1;
  localparam logic CFG_LINEAR_RST = 1'b1;
  localparam logic CFG_DESEL_RST = 1'b1;

  localparam int STAT_OP_LSB = 0;
  localparam int STAT_CNT_LSB = 5;
  localparam int STAT_BASE_LSB = 7;
  localparam int STAT_DRIVE_BIT = 9;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [4:0] {
    OP_DESEL = 5'h01,
    OP_BEGIN_RD = 5'h02,
    OP_BEGIN_WR = 5'h04,
    OP_CONT = 5'h08,
    OP_SUSP = 5'h10
  } sbs_op_type;

endpackage : sbs_pkg

/* src/sbs_lane.sv */
// One byte lane of the storage array, written per lane and read by index.
`timescale 1ns/1ps
module sbs_lane (
  input wire logic aclk,
  input wire logic wr_en,
  input wire logic [sbs_pkg::ADDR_W-1:0] wr_idx,
  input wire logic [sbs_pkg::LANE_W-1:0] wr_data,
  input wire logic [sbs_pkg::ADDR_W-1:0] rd_idx,
  output logic [sbs_pkg::LANE_W-1:0] rd_data
);

  logic [sbs_pkg::LANE_W-1:0] mem_r [sbs_pkg::DEPTH];

  // Stored bytes are not reset; only the control state needs a defined start.
  always_ff @(posedge aclk) begin
    if (wr_en) begin
      mem_r[wr_idx] <= wr_data; // [RL2]
    end
  end

  assign rd_data = mem_r[rd_idx];

endmodule : sbs_lane

/* src/sbs_sram_ctrl.sv */
// Synchronous burst SRAM control: cycle decode, burst counter, lanes, output path and AXI4-Lite config.
`timescale 1ns/1ps
module sbs_sram_ctrl (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [sbs_pkg::AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [sbs_pkg::AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic chip_select_n,
  input wire logic cpu_addr_strobe_n,
  input wire logic ctrl_addr_strobe_n,
  input wire logic burst_step_n,
  input wire logic all_lanes_write_n,
  input wire logic lane_write_gate_n,
  input wire logic lane0_write_n,
  input wire logic lane1_write_n,
  input wire logic lane2_write_n,
  input wire logic lane3_write_n,
  input wire logic out_enable_n,
  input wire logic [sbs_pkg::ADDR_W-1:0] sram_addr,
  input wire logic [sbs_pkg::DATA_W-1:0] dq_in,
  output logic [sbs_pkg::DATA_W-1:0] dq_out,
  output logic [sbs_pkg::LANE_CNT-1:0] dq_oe
);

  // Configuration bits, written over the register bus.
  logic flowthru_sel_n_r;
  logic linear_order_n_r;
  logic deselect_depth_sel_r;

  // Burst address state.
  logic [sbs_pkg::ADDR_W-3:0] hi_r;
  logic [1:0] base_r;
  logic [1:0] cnt_r;
  logic [1:0] cnt_nxt;
  logic [1:0] base_nxt;
  logic [sbs_pkg::ADDR_W-3:0] hi_nxt;

  // Output path state.
  logic rd1_r;
  logic [sbs_pkg::DATA_W-1:0] q1_r;
  logic [sbs_pkg::DATA_W-1:0] dq_out_r;
  logic drive_r;
  logic drive_nxt;
  sbs_pkg::sbs_op_type op_last_r;

  // Cycle decode.
  sbs_pkg::sbs_op_type op;
  logic [sbs_pkg::LANE_CNT-1:0] lane_n;
  logic [sbs_pkg::LANE_CNT-1:0] lane_we;
  logic wr_ind;
  logic do_read;
  logic do_write;
  logic [sbs_pkg::ADDR_W-1:0] acc_addr;
  logic [1:0] acc_lo;
  logic [sbs_pkg::DATA_W-1:0] rd_word;

  // AXI state.
  logic awready_r;
  logic wready_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic arready_r;
  logic rvalid_r;
  logic [1:0] rresp_r;
  logic [31:0] rdata_r;
  logic aw_have_r;
  logic w_have_r;
  logic [sbs_pkg::AXI_AW-1:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic [31:0] status_word;

  function automatic logic [1:0] burst_lo(input logic [1:0] start, input logic [1:0] count, input logic linear);
    logic [1:0] res;
    res = linear ? 2'(start + count) : (start ^ count); // [RL17]
    return res;
  endfunction : burst_lo

  // Lanes two and three only exist because this build is the 36-bit one.
  assign lane_n = {lane3_write_n, lane2_write_n, lane1_write_n, lane0_write_n}; // [RL5]

  // Global write overrides the byte controls entirely.
  assign wr_ind = !all_lanes_write_n || (!lane_write_gate_n && !(&lane_n)); // [RL1]

  always_comb begin
    if (!all_lanes_write_n) begin
      lane_we = '1; // [RL1]
    end else if (!lane_write_gate_n) begin
      lane_we = ~lane_n; // [RL2]
    end else begin
      lane_we = '0;
    end
  end

  always_comb begin
    if (chip_select_n && !ctrl_addr_strobe_n) begin
      op = sbs_pkg::OP_DESEL; // [RL7]
    end else if (!chip_select_n && !cpu_addr_strobe_n) begin
      op = sbs_pkg::OP_BEGIN_RD; // [RL8]
    end else if (!chip_select_n && !ctrl_addr_strobe_n) begin
      op = wr_ind ? sbs_pkg::OP_BEGIN_WR : sbs_pkg::OP_BEGIN_RD; // [RL8] [RL9]
    end else if (!burst_step_n) begin
      op = sbs_pkg::OP_CONT; // [RL10]
    end else begin
      op = sbs_pkg::OP_SUSP; // [RL11]
    end
  end

  always_comb begin
    hi_nxt = hi_r;
    base_nxt = base_r;
    cnt_nxt = cnt_r;
    do_read = 1'b0;
    do_write = 1'b0;
    case (op)
      sbs_pkg::OP_DESEL: begin
        do_read = 1'b0; // [RL7]
      end
      sbs_pkg::OP_BEGIN_RD: begin
        hi_nxt = sram_addr[sbs_pkg::ADDR_W-1:2];
        base_nxt = sram_addr[1:0]; // [RL16]
        cnt_nxt = 2'h0;
        do_read = 1'b1; // [RL8]
      end
      sbs_pkg::OP_BEGIN_WR: begin
        hi_nxt = sram_addr[sbs_pkg::ADDR_W-1:2];
        base_nxt = sram_addr[1:0]; // [RL16]
        cnt_nxt = 2'h0;
        do_write = 1'b1; // [RL9]
      end
      sbs_pkg::OP_CONT: begin
        // The count wraps modulo four, so the fifth access returns to the start.
        cnt_nxt = 2'(cnt_r + 2'h1); // [RL10] [RL16]
        do_read = !wr_ind;
        do_write = wr_ind;
      end
      sbs_pkg::OP_SUSP: begin
        do_read = !wr_ind; // [RL11]
        do_write = wr_ind;
      end
      default: begin
        do_read = 1'b0;
      end
    endcase
  end

  assign acc_lo = burst_lo(base_nxt, cnt_nxt, !linear_order_n_r);
  assign acc_addr = {hi_nxt, acc_lo};

  generate
    for (genvar g = 0; g < sbs_pkg::LANE_CNT; g++) begin : g_lane
      sbs_lane u_lane (
        .aclk(aclk),
        .wr_en(do_write && lane_we[g]), // [RL2]
        .wr_idx(acc_addr),
        .wr_data(dq_in[g*sbs_pkg::LANE_W +: sbs_pkg::LANE_W]),
        .rd_idx(acc_addr),
        .rd_data(rd_word[g*sbs_pkg::LANE_W +: sbs_pkg::LANE_W])
      );
    end
  endgenerate

  // The counter moves on every continue cycle and holds on suspend cycles, whatever output enable does.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hi_r <= '0;
      base_r <= 2'h0;
      cnt_r <= 2'h0;
      op_last_r <= sbs_pkg::OP_DESEL;
    end else begin
      hi_r <= hi_nxt;
      base_r <= base_nxt;
      cnt_r <= cnt_nxt; // [RL12]
      op_last_r <= op;
    end
  end

  // Pipeline first stage: the word fetched at the read edge.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd1_r <= 1'b0;
      q1_r <= '0;
    end else begin
      rd1_r <= do_read;
      if (do_read) begin
        q1_r <= rd_word;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dq_out_r <= '0;
    end else if (!flowthru_sel_n_r) begin
      if (do_read) begin
        dq_out_r <= rd_word; // [RL18]
      end
    end else if (rd1_r) begin
      dq_out_r <= q1_r; // [RL18] [RL19]
    end
  end

  // Single deselect cuts the pipeline drive at the deselect edge; dual lets it run one more cycle.
  always_comb begin
    if (!flowthru_sel_n_r) begin
      drive_nxt = do_read; // [RL3] [RL4]
    end else begin
      drive_nxt = rd1_r && !do_write && !(op == sbs_pkg::OP_DESEL && deselect_depth_sel_r); // [RL4] [RL19]
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      drive_r <= 1'b0;
    end else begin
      drive_r <= drive_nxt;
    end
  end

  assign dq_out = dq_out_r;
  // Output enable gates the drivers without a clock so it can pull them off mid-cycle.
  assign dq_oe = {sbs_pkg::LANE_CNT{drive_r && !out_enable_n}}; // [RL3] [RL6] [RL12]

  // Register bus: write address and data are taken independently, answered once both are held.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_r <= 1'b1;
      aw_have_r <= 1'b0;
      awaddr_r <= '0;
    end else if (s_axi_awvalid && awready_r) begin
      awready_r <= 1'b0;
      aw_have_r <= 1'b1;
      awaddr_r <= s_axi_awaddr;
    end else if (bvalid_r && s_axi_bready) begin
      awready_r <= 1'b1;
      aw_have_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready_r <= 1'b1;
      w_have_r <= 1'b0;
      wdata_r <= '0;
      wstrb_r <= '0;
    end else if (s_axi_wvalid && wready_r) begin
      wready_r <= 1'b0;
      w_have_r <= 1'b1;
      wdata_r <= s_axi_wdata;
      wstrb_r <= s_axi_wstrb;
    end else if (bvalid_r && s_axi_bready) begin
      wready_r <= 1'b1;
      w_have_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r <= sbs_pkg::RESP_OKAY;
    end else if (aw_have_r && w_have_r && !bvalid_r) begin
      bvalid_r <= 1'b1;
      if (awaddr_r == sbs_pkg::CFG_OFFSET || awaddr_r == sbs_pkg::STATUS_OFFSET) begin
        bresp_r <= sbs_pkg::RESP_OKAY;
      end else begin
        bresp_r <= sbs_pkg::RESP_SLVERR;
      end
    end else if (bvalid_r && s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // Mode changes apply from the next SRAM cycle; software should change them while the bus is idle.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flowthru_sel_n_r <= sbs_pkg::CFG_FLOWTHRU_RST;
      linear_order_n_r <= sbs_pkg::CFG_LINEAR_RST;
      deselect_depth_sel_r <= sbs_pkg::CFG_DESEL_RST;
    end else if (aw_have_r && w_have_r && !bvalid_r && awaddr_r == sbs_pkg::CFG_OFFSET && wstrb_r[0]) begin
      flowthru_sel_n_r <= wdata_r[sbs_pkg::CFG_FLOWTHRU_BIT]; // [RL18]
      linear_order_n_r <= wdata_r[sbs_pkg::CFG_LINEAR_BIT]; // [RL17]
      deselect_depth_sel_r <= wdata_r[sbs_pkg::CFG_DESEL_BIT]; // [RL19]
    end
  end

  always_comb begin
    status_word = '0;
    status_word[sbs_pkg::STAT_OP_LSB +: 5] = op_last_r;
    status_word[sbs_pkg::STAT_CNT_LSB +: 2] = cnt_r;
    status_word[sbs_pkg::STAT_BASE_LSB +: 2] = base_r;
    status_word[sbs_pkg::STAT_DRIVE_BIT] = drive_r;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rresp_r <= sbs_pkg::RESP_OKAY;
      rdata_r <= '0;
    end else if (s_axi_arvalid && arready_r) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b1;
      if (s_axi_araddr == sbs_pkg::CFG_OFFSET) begin
        rdata_r <= {29'h0, deselect_depth_sel_r, linear_order_n_r, flowthru_sel_n_r};
        rresp_r <= sbs_pkg::RESP_OKAY;
      end else if (s_axi_araddr == sbs_pkg::STATUS_OFFSET) begin
        rdata_r <= status_word;
        rresp_r <= sbs_pkg::RESP_OKAY;
      end else begin
        rdata_r <= '0;
        rresp_r <= sbs_pkg::RESP_SLVERR;
      end
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_r <= 1'b0;
      arready_r <= 1'b1;
    end
  end

  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp = rresp_r;
  assign s_axi_rdata = rdata_r;

endmodule : sbs_sram_ctrl

/* dv/sbs_host_model.sv */
// Processor-side model that drives the synchronous SRAM control pins one cycle at a time.
`timescale 1ns/1ps
module sbs_host_model (
  input wire logic aclk,
  output logic chip_select_n,
  output logic cpu_addr_strobe_n,
  output logic ctrl_addr_strobe_n,
  output logic burst_step_n,
  output logic all_lanes_write_n,
  output logic lane_write_gate_n,
  output logic [3:0] lanes_n,
  output logic out_enable_n,
  output logic [sbs_pkg::ADDR_W-1:0] sram_addr,
  output logic [sbs_pkg::DATA_W-1:0] dq_in
);
  initial begin
    {chip_select_n, cpu_addr_strobe_n, ctrl_addr_strobe_n, burst_step_n} = 4'b1101;
    {all_lanes_write_n, lane_write_gate_n, out_enable_n} = 3'b111;
    lanes_n = 4'hF;
    sram_addr = 4'h0;
    dq_in = 36'h0;
  end

  // One call drives one bus cycle, which the device samples at the next rising edge.
  task automatic cyc(input logic [3:0] ct, input logic [1:0] wm, input logic [3:0] ln, input logic oe,
                     input logic [sbs_pkg::ADDR_W-1:0] a, input logic [sbs_pkg::DATA_W-1:0] d);
    logic wr;
    wr = !wm[1] || (!wm[0] && ln != 4'hF);
    @(posedge aclk);
    {chip_select_n, cpu_addr_strobe_n, ctrl_addr_strobe_n, burst_step_n} <= ct;
    {all_lanes_write_n, lane_write_gate_n} <= wm;
    lanes_n <= ln;
    sram_addr <= a;
    // Output enable stays high on writes so the device drivers are off before data is driven.
    out_enable_n <= oe || wr;
    // A released data bus shows the inverse of its last value, never a stale copy.
    dq_in <= wr ? d : ~dq_in;
  endtask : cyc
endmodule : sbs_host_model

/* dv/sbs_sram_ctrl_properties.sv */
// Checker of data-driver and handshake behaviour at the SRAM control ports.
`timescale 1ns/1ps
module sbs_sram_ctrl_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awready,
  input wire logic s_axi_arready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic chip_select_n,
  input wire logic cpu_addr_strobe_n,
  input wire logic ctrl_addr_strobe_n,
  input wire logic all_lanes_write_n,
  input wire logic lane_write_gate_n,
  input wire logic lane0_write_n,
  input wire logic lane1_write_n,
  input wire logic lane2_write_n,
  input wire logic lane3_write_n,
  input wire logic out_enable_n,
  input wire logic [sbs_pkg::LANE_CNT-1:0] dq_oe
);
  logic desel, wr_ind, rd, wr;
  assign desel = chip_select_n && !ctrl_addr_strobe_n;
  assign wr_ind = !all_lanes_write_n ||
                  (!lane_write_gate_n && !(lane0_write_n && lane1_write_n && lane2_write_n && lane3_write_n));
  assign rd = !desel && ((!chip_select_n && !cpu_addr_strobe_n) || !wr_ind);
  assign wr = !desel && !rd;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_write_hi_z: assert property (wr |=> dq_oe == 4'h0)
    else $error("data drivers on after a write cycle");
  a_oe_gate: assert property (out_enable_n |-> dq_oe == 4'h0)
    else $error("data drivers on while output enable is high");
  a_lanes_all: assert property (dq_oe != 4'h0 |-> dq_oe == 4'hF && ($past(rd) || $past(rd, 2)))
    else $error("byte lanes driven unequally or without a read");
  a_desel_off: assert property (desel ##1 desel |=> dq_oe == 4'h0)
    else $error("data drivers on after two deselect cycles");
  a_read_drive: assert property (rd ##1 rd ##1 !out_enable_n |-> dq_oe == 4'hF)
    else $error("data drivers off during a read run");
  a_reset_quiet: assert property (disable iff (1'b0)
      !aresetn |=> s_axi_awready && s_axi_arready && !s_axi_bvalid && !s_axi_rvalid && dq_oe == 4'h0)
    else $error("outputs not at reset state");
  a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped before taken");
  a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("read response dropped before taken");
endmodule : sbs_sram_ctrl_checker

bind sbs_sram_ctrl sbs_sram_ctrl_checker i_chk (.*);

/* dv/sbs_sram_ctrl_tb.sv */
// Self-checking bench of the SRAM control block: register setup, writes, then burst reads.
`timescale 1ns/1ps
module sbs_sram_ctrl_tb;
  logic aclk, aresetn;
  logic [sbs_pkg::AXI_AW-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb, lanes_n;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic chip_select_n, cpu_addr_strobe_n, ctrl_addr_strobe_n, burst_step_n, out_enable_n;
  logic all_lanes_write_n, lane_write_gate_n, lane0_write_n, lane1_write_n, lane2_write_n, lane3_write_n;
  logic [sbs_pkg::ADDR_W-1:0] sram_addr;
  logic [sbs_pkg::DATA_W-1:0] dq_in, dq_out, em [16];
  logic [sbs_pkg::LANE_CNT-1:0] dq_oe;
  int n_fail, num_checks;
  assign {lane3_write_n, lane2_write_n, lane1_write_n, lane0_write_n} = lanes_n;
  sbs_sram_ctrl i_dut (.*);
  sbs_host_model i_host (.*);

  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : summarize

  task automatic cmp(input string nm, input logic [35:0] e, input logic [35:0] g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %0h seen %0h", nm, e, g);
    end
  endtask : cmp

  // Each bus task starts one edge on, so a ready or valid lowered by the previous call is never raised again
  // in the same time step.
  task automatic axw(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) break;
    end
    if (n == 50) begin
      n_fail++;
      summarize();
    end
    s_axi_bready <= 1'b0;
    cmp("bresp", {34'h0, r}, {34'h0, s_axi_bresp});
  endtask : axw

  task automatic axr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) break;
    end
    if (n == 50) begin
      n_fail++;
      summarize();
    end
    s_axi_rready <= 1'b0;
    cmp("rdata", {4'h0, d}, {4'h0, s_axi_rdata});
    cmp("rresp", {34'h0, r}, {34'h0, s_axi_rresp});
  endtask : axr

  function automatic logic [35:0] pat(input logic [3:0] a);
    return {a, 5'h11, a, 5'h0A, a, 5'h15, a, 5'h06};
  endfunction : pat

  // The expected memory follows the lane rules, so a wrong lane mask shows up on read-back.
  task automatic wr1(input logic [3:0] ct, input logic [3:0] a, input logic [35:0] d, input logic [1:0] wm,
                     input logic [3:0] ln);
    int g;
    i_host.cyc(ct, wm, ln, 1'b0, a, d);
    for (g = 0; g < 4; g++) begin
      if (!wm[1] || (!wm[0] && !ln[g])) em[a][g*9+:9] = d[g*9+:9];
    end
  endtask : wr1

  // Five reads from one start, suspended where st is set, the first nd of them dummy reads.
  // The driver state eoe is checked at the same edge at which the last read reaches the output.
  task automatic rdb(input logic [3:0] a, input logic o, input int lat, input logic [4:0] st, input int nd,
                     input logic bs, input logic [3:0] eoe);
    logic [1:0] c;
    logic [3:0] ea [5];
    int j;
    c = 2'h0;
    for (j = 0; j < 5 + lat; j++) begin
      if (j > 0 && j < 5 && !st[j]) c = c + 2'h1;
      if (j < 5) ea[j] = {a[3:2], o ? a[1:0] ^ c : a[1:0] + c};
      i_host.cyc(j == 0 ? {1'b0, bs, !bs, 1'b1} : (j < 5 ? {3'b111, st[j]} : 4'b1101), 2'b11, 4'hF,
                 j < nd, a, 36'h0);
      #1;
      if (j >= lat + nd && j < 5 + lat) cmp("dq_out", em[ea[j - lat]], dq_out);
      if (j == 4 + lat) cmp("dq_oe", {32'h0, eoe}, {32'h0, dq_oe});
    end
  endtask : rdb

  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  initial begin
    int a;
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    n_fail = 0;
    num_checks = 0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    axr(sbs_pkg::CFG_OFFSET, 32'h7, sbs_pkg::RESP_OKAY);
    axr(4'h8, 32'h0, sbs_pkg::RESP_SLVERR);
    axw(4'hC, 32'h0, sbs_pkg::RESP_SLVERR);
    axw(sbs_pkg::CFG_OFFSET, 32'h1, sbs_pkg::RESP_OKAY);
    for (a = 0; a < 16; a++) wr1(4'b0101, a[3:0], pat(a[3:0]), 2'b01, 4'h0);
    wr1(4'b0101, 4'h6, 36'h0, 2'b10, 4'b1010);
    wr1(4'b0101, 4'h7, 36'h0, 2'b10, 4'b0111);
    wr1(4'b0101, 4'h5, 36'h0, 2'b11, 4'h0);
    wr1(4'b0101, 4'h4, 36'h0, 2'b10, 4'hF);
    wr1(4'b0101, 4'h8, ~pat(4'h8), 2'b01, 4'hF);
    wr1(4'b1110, 4'h9, ~pat(4'h9), 2'b01, 4'hF);
    wr1(4'b1111, 4'h9, 36'h0, 2'b01, 4'hF);
    rdb(4'h5, 1'b0, 2, 5'h00, 0, 1'b0, 4'hF);
    rdb(4'h8, 1'b0, 2, 5'h00, 0, 1'b0, 4'hF);
    rdb(4'h4, 1'b0, 2, 5'h04, 2, 1'b1, 4'hF);
    axw(sbs_pkg::CFG_OFFSET, 32'h5, sbs_pkg::RESP_OKAY);
    rdb(4'h2, 1'b0, 2, 5'h00, 0, 1'b0, 4'h0);
    axw(sbs_pkg::CFG_OFFSET, 32'h6, sbs_pkg::RESP_OKAY);
    axr(sbs_pkg::CFG_OFFSET, 32'h6, sbs_pkg::RESP_OKAY);
    rdb(4'hD, 1'b1, 1, 5'h00, 0, 1'b0, 4'hF);
    i_host.cyc(4'b1101, 2'b11, 4'hF, 1'b0, 4'h0, 36'h0);
    #1;
    cmp("dq_oe", 36'h0, {32'h0, dq_oe});
    summarize();
  end
endmodule : sbs_sram_ctrl_tb
